/* File: core/scfg_map.svh */
// Purpose: offsets, field positions, decode bases and timing counts
// Assumes: 10-bit ISA I/O addresses, 8-bit data
// Notes: definitions only
`ifndef SCFG_MAP_SVH
`define SCFG_MAP_SVH
`define SCFG_UNLOCK_PORT 10'h250
`define SCFG_INDEX_PORT 10'h251
`define SCFG_DATA_PORT 10'h252
`define SCFG_KEY_A 8'h89
`define SCFG_KEY_B 8'h88
`define SCFG_IDX_CR0 4'h0
`define SCFG_IDX_CR1 4'h1
`define SCFG_IDX_CR2 4'h2
`define SCFG_IDX_CR3 4'h3
// cr0 fields
`define SCFG_HDD_DIS 7
`define SCFG_HDD_SEL 6
`define SCFG_FDC_DIS 5
`define SCFG_FDC_SEL 4
// cr1 fields
`define SCFG_SWAP 7
// cr2 field
`define SCFG_CMP_WIDTH 0
// cr3 fields
`define SCFG_B_MIDI 0
`define SCFG_A_MIDI 1
`define SCFG_B_ADDR2 2
`define SCFG_A_ADDR2 3
// decode bases
`define SCFG_HDD_PRI 10'h1f0
`define SCFG_HDD_PRI_ALT 10'h3f6
`define SCFG_HDD_SEC 10'h170
`define SCFG_HDD_SEC_ALT 10'h376
`define SCFG_FDC_PRI 10'h3f0
`define SCFG_FDC_SEC 10'h370
`define SCFG_COM1 10'h3f8
`define SCFG_COM2 10'h2f8
`define SCFG_COM3 10'h3e8
`define SCFG_COM4 10'h2e8
`define SCFG_LPT1 10'h378
`define SCFG_LPT2 10'h278
`define SCFG_LPT3 10'h3bc
// timing
`define SCFG_CLK_KHZ 100000
`define SCFG_SETTLE_MS 128
`define SCFG_DIV_STD 4'hd
`define SCFG_DIV_MIDI 4'hc
`endif

/* File: core/scfg_pkg.sv */
// Purpose: types shared by the configuration block
// Assumes: nothing
// Notes: power codes equal cr0 bits 1:0
package scfg_pkg;
   typedef enum logic [1:0] {
      SCFG_PWR_RUN = 2'b00,
      SCFG_PWR_IMM = 2'b01,
      SCFG_PWR_ARM = 2'b10,
      SCFG_PWR_AUTO = 2'b11
   } scfg_pwr_t;
   typedef enum logic [2:0] {
      SCFG_LPT_LEGACY = 3'b000,
      SCFG_LPT_EXT_FDD = 3'b001,
      SCFG_LPT_EXT_ADP = 3'b010,
      SCFG_LPT_EXT_2FDD = 3'b011,
      SCFG_LPT_JOY = 3'b100,
      SCFG_LPT_EPP = 3'b101,
      SCFG_LPT_ECP = 3'b110,
      SCFG_LPT_ECP_EPP = 3'b111
   } scfg_lpt_t;
endpackage : scfg_pkg

/* File: core/scfg_top.sv */
// Purpose: indexed configuration and power-down block
// Assumes: io_rd/io_wr are levels synchronous to mclk, address held with them
// Notes: rst is the cold (master) reset; straps load on first enabled edge after it
`include "scfg_map.svh"
module scfg_top #(
   parameter int CW = 24,
   parameter logic [23:0] SETTLE_CYC = 24'(`SCFG_SETTLE_MS * `SCFG_CLK_KHZ),
   parameter logic [23:0] IDLE_CYC0 = 24'd100000,
   parameter logic [23:0] IDLE_CYC1 = 24'd200000,
   parameter logic [23:0] IDLE_CYC2 = 24'd400000,
   parameter logic [23:0] IDLE_CYC3 = 24'd800000
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic ce,
   input wire logic [9:0] io_addr,
   input wire logic io_rd,
   input wire logic io_wr,
   input wire logic [7:0] io_wdata,
   output logic [7:0] io_rdata,
   output logic io_rdata_oe,
   input wire logic strap_hdd_dis,
   input wire logic strap_hdd_sel,
   input wire logic strap_fdc_dis,
   input wire logic strap_fdc_sel,
   input wire logic strap_swap,
   input wire logic [1:0] strap_ser_a,
   input wire logic [1:0] strap_ser_b,
   input wire logic [1:0] strap_lpt,
   input wire logic lpt_mode_bit2,
   input wire logic power_select_bit2,
   input wire logic [1:0] idle_timer_sel,
   input wire logic fdc_busy,
   input wire logic fdc_motor_on,
   input wire logic uart_irq_src,
   input wire logic serial_a_out,
   input wire logic serial_b_out,
   input wire logic serial_a_in,
   input wire logic serial_b_in,
   input wire logic adapter_dma_ack,
   output logic hdd_hit,
   output logic fdc_hit,
   output logic ser_a_hit,
   output logic ser_b_hit,
   output logic lpt_hit,
   output logic fdc_clk_en,
   output logic ser_a_clk_en,
   output logic ser_b_clk_en,
   output logic lpt_en,
   output scfg_pkg::scfg_lpt_t lpt_mode,
   output logic drive_swap,
   output logic [3:0] ser_a_div,
   output logic [3:0] ser_b_div,
   output logic osc_run,
   output logic int_clk_run,
   output logic settling,
   output logic adapter_read_strobe_n,
   output logic adapter_write_strobe_n,
   output logic [7:0] adapter_data_lines,
   output logic adapter_data_oe,
   output logic [2:0] adapter_addr_low
);
   import scfg_pkg::*;

   logic [7:0] cr0_q, cr0_d, cr1_q, cr1_d, cr2_q, cr2_d, cr3_q, cr3_d;
   logic [3:0] idx_q, idx_d;
   logic unlock_q, unlock_d, done_q, done_d, idle_q, idle_d;
   logic [CW-1:0] cnt_q, cnt_d, settle_q, settle_d;
   logic [7:0] rdata_d;
   logic rdoe_d, hdd_d, fdc_d, sa_d, sb_d, lpt_d;
   logic rstb_d, wstb_d, xoe_d;
   logic [7:0] xd_d;
   logic osc_d, iclk_d;
   scfg_pwr_t pwr_now;
   scfg_lpt_t mode_now;
   logic acc, wr_dat, rd_dat, ext_adp, ad_hit, idle, idle_chg;
   logic [9:0] hdd_b, hdd_alt, fdc_b, sa_b, sb_b, lpt_b;
   logic [CW-1:0] idle_load;

   function automatic logic [9:0] sa_base(input logic hi, input logic [1:0] s);
      logic [9:0] b;
      b = `SCFG_COM1;
      if (hi)
      begin
         b = `SCFG_COM2;
      end
      else if (s == 2'b00)
      begin
         b = `SCFG_COM4;
      end
      else if (s == 2'b01)
      begin
         b = `SCFG_COM3;
      end
      return b;
   endfunction : sa_base

   function automatic logic [9:0] sb_base(input logic hi, input logic [1:0] s);
      logic [9:0] b;
      b = `SCFG_COM2;
      if (hi)
      begin
         b = `SCFG_COM1;
      end
      else if (s == 2'b00)
      begin
         b = `SCFG_COM3;
      end
      else if (s == 2'b01)
      begin
         b = `SCFG_COM4;
      end
      return b;
   endfunction : sb_base

   always_comb
   begin
      pwr_now = scfg_pwr_t'(cr0_q[1:0]);
      mode_now = scfg_lpt_t'({lpt_mode_bit2, cr0_q[3:2]});
      ext_adp = (mode_now == SCFG_LPT_EXT_ADP);
      acc = io_rd | io_wr;
      wr_dat = io_wr && unlock_q && (io_addr == `SCFG_DATA_PORT);
      rd_dat = io_rd && unlock_q && (io_addr == `SCFG_DATA_PORT);
      // address decode
      hdd_b = cr0_q[`SCFG_HDD_SEL] ? `SCFG_HDD_PRI : `SCFG_HDD_SEC;
      hdd_alt = cr0_q[`SCFG_HDD_SEL] ? `SCFG_HDD_PRI_ALT : `SCFG_HDD_SEC_ALT;
      fdc_b = cr0_q[`SCFG_FDC_SEL] ? `SCFG_FDC_PRI : `SCFG_FDC_SEC;
      sa_b = sa_base(cr3_q[`SCFG_A_ADDR2], {cr1_q[2], cr1_q[0]});
      sb_b = sb_base(cr3_q[`SCFG_B_ADDR2], {cr1_q[3], cr1_q[1]});
      unique case (cr1_q[5:4])
         2'b00: lpt_b = `SCFG_LPT3;
         2'b01: lpt_b = `SCFG_LPT2;
         default: lpt_b = `SCFG_LPT1;
      endcase
      hdd_d = acc && !cr0_q[`SCFG_HDD_DIS]
         && (io_addr[9:3] == hdd_b[9:3] || io_addr[9:1] == hdd_alt[9:1]);
      fdc_d = acc && !cr0_q[`SCFG_FDC_DIS] && io_addr[9:3] == fdc_b[9:3];
      sa_d = acc && ({cr1_q[2], cr1_q[0]} != 2'b11 || cr3_q[`SCFG_A_ADDR2])
         && io_addr[9:3] == sa_b[9:3];
      sb_d = acc && ({cr1_q[3], cr1_q[1]} != 2'b11 || cr3_q[`SCFG_B_ADDR2])
         && io_addr[9:3] == sb_b[9:3];
      lpt_d = acc && cr1_q[5:4] != 2'b11 && io_addr[9:2] == lpt_b[9:2];
      ad_hit = cr2_q[`SCFG_CMP_WIDTH] ? (io_addr[9:4] == cr2_q[7:2])
         : (io_addr[9:3] == cr2_q[7:1]);
      // idle conditions for automatic sleep
      idle = !fdc_busy && !fdc_motor_on && !uart_irq_src
         && serial_a_out && serial_b_out && serial_a_in && serial_b_in
         && !(acc && (hdd_d || fdc_d || sa_d || sb_d || lpt_d
         || (io_addr >> 2) == (`SCFG_UNLOCK_PORT >> 2)));
      idle_d = idle;
      idle_chg = (idle != idle_q);
      unique case (idle_timer_sel)
         2'b00: idle_load = IDLE_CYC0;
         2'b01: idle_load = IDLE_CYC1;
         2'b10: idle_load = IDLE_CYC2;
         default: idle_load = IDLE_CYC3;
      endcase
      // register file
      cr0_d = cr0_q;
      cr1_d = cr1_q;
      cr2_d = cr2_q;
      cr3_d = cr3_q;
      idx_d = idx_q;
      unlock_d = unlock_q;
      done_d = 1'b1;
      if (!done_q)
      begin
         // straps load once after cold reset
         cr0_d[`SCFG_HDD_DIS] = strap_hdd_dis;
         cr0_d[`SCFG_HDD_SEL] = strap_hdd_sel;
         cr0_d[`SCFG_FDC_DIS] = strap_fdc_dis;
         cr0_d[`SCFG_FDC_SEL] = strap_fdc_sel;
         cr1_d[`SCFG_SWAP] = strap_swap;
         {cr1_d[2], cr1_d[0]} = strap_ser_a;
         {cr1_d[3], cr1_d[1]} = strap_ser_b;
         cr1_d[5:4] = strap_lpt;
      end
      if (io_wr && io_addr == `SCFG_UNLOCK_PORT)
      begin
         unlock_d = (io_wdata == `SCFG_KEY_A) || (io_wdata == `SCFG_KEY_B);
      end
      if (io_wr && unlock_q && io_addr == `SCFG_INDEX_PORT)
      begin
         idx_d = io_wdata[3:0];
      end
      if (wr_dat)
      begin
         unique case (idx_q)
            `SCFG_IDX_CR0: cr0_d = io_wdata;
            `SCFG_IDX_CR1: cr1_d = io_wdata;
            `SCFG_IDX_CR2: cr2_d = io_wdata;
            `SCFG_IDX_CR3: cr3_d = io_wdata;
            default: cr0_d = cr0_d;
         endcase
      end
      rdoe_d = rd_dat;
      rdata_d = 8'h00;
      if (rd_dat)
      begin
         unique case (idx_q)
            `SCFG_IDX_CR0: rdata_d = cr0_q;
            `SCFG_IDX_CR1: rdata_d = cr1_q;
            `SCFG_IDX_CR2: rdata_d = cr2_q;
            `SCFG_IDX_CR3: rdata_d = cr3_q;
            default: rdata_d = 8'h00;
         endcase
      end
      // power-down sequencing; a host write to cr0 takes precedence
      cnt_d = cnt_q;
      if (!(wr_dat && idx_q == `SCFG_IDX_CR0))
      begin
         unique case (pwr_now)
            SCFG_PWR_ARM:
            begin
               if (!idle || idle_chg)
               begin
                  cnt_d = idle_load;
               end
               else if (cnt_q == '0)
               begin
                  cr0_d[1:0] = SCFG_PWR_AUTO;
               end
               else
               begin
                  cnt_d = cnt_q - 1'b1;
               end
            end
            SCFG_PWR_AUTO:
            begin
               if (idle_chg)
               begin
                  cr0_d[1:0] = SCFG_PWR_ARM;
                  cnt_d = idle_load;
               end
            end
            default: cnt_d = idle_load;
         endcase
      end
      else
      begin
         cnt_d = idle_load;
      end
      settle_d = settle_q;
      if (pwr_now == SCFG_PWR_IMM && cr0_d[1:0] != SCFG_PWR_IMM)
      begin
         settle_d = SETTLE_CYC;
      end
      else if (settle_q != '0)
      begin
         settle_d = settle_q - 1'b1;
      end
      osc_d = (cr0_d[1:0] != SCFG_PWR_IMM);
      iclk_d = osc_d && settle_d == '0
         && cr0_d[1:0] != SCFG_PWR_AUTO
         && !(cr0_d[1:0] == SCFG_PWR_RUN && power_select_bit2);
      // adapter strobes and data lines
      rstb_d = 1'b0;
      wstb_d = 1'b0;
      xoe_d = 1'b0;
      xd_d = adapter_data_lines;
      if (ext_adp && wr_dat && idx_q == `SCFG_IDX_CR2)
      begin
         rstb_d = 1'b1;
         wstb_d = 1'b1;
         xoe_d = 1'b1;
         xd_d = io_wdata;
      end
      else if (ext_adp && (ad_hit || adapter_dma_ack))
      begin
         rstb_d = io_rd;
         wstb_d = io_wr;
         xoe_d = io_wr;
         if (io_wr)
         begin
            xd_d = io_wdata;
         end
      end
   end

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         // cold reset only; warm reset has no path here
         cr0_q <= 8'h00;
         cr1_q <= 8'h00;
         cr2_q <= 8'h00;
         cr3_q <= 8'h00;
         idx_q <= 4'h0;
         unlock_q <= 1'b0;
         done_q <= 1'b0;
         idle_q <= 1'b0;
         cnt_q <= '0;
         settle_q <= '0;
         io_rdata <= 8'h00;
         io_rdata_oe <= 1'b0;
         hdd_hit <= 1'b0;
         fdc_hit <= 1'b0;
         ser_a_hit <= 1'b0;
         ser_b_hit <= 1'b0;
         lpt_hit <= 1'b0;
         fdc_clk_en <= 1'b0;
         ser_a_clk_en <= 1'b0;
         ser_b_clk_en <= 1'b0;
         lpt_en <= 1'b0;
         lpt_mode <= SCFG_LPT_LEGACY;
         drive_swap <= 1'b0;
         ser_a_div <= `SCFG_DIV_STD;
         ser_b_div <= `SCFG_DIV_STD;
         osc_run <= 1'b1;
         int_clk_run <= 1'b1;
         settling <= 1'b0;
         adapter_read_strobe_n <= 1'b1;
         adapter_write_strobe_n <= 1'b1;
         adapter_data_lines <= 8'h00;
         adapter_data_oe <= 1'b0;
         adapter_addr_low <= 3'h0;
      end
      else if (ce)
      begin
         cr0_q <= cr0_d;
         cr1_q <= cr1_d;
         cr2_q <= cr2_d;
         cr3_q <= cr3_d;
         idx_q <= idx_d;
         unlock_q <= unlock_d;
         done_q <= done_d;
         idle_q <= idle_d;
         cnt_q <= cnt_d;
         settle_q <= settle_d;
         io_rdata <= rdata_d;
         io_rdata_oe <= rdoe_d;
         hdd_hit <= hdd_d;
         fdc_hit <= fdc_d;
         ser_a_hit <= sa_d;
         ser_b_hit <= sb_d;
         lpt_hit <= lpt_d;
         fdc_clk_en <= !cr0_d[`SCFG_FDC_DIS];
         ser_a_clk_en <= {cr1_d[2], cr1_d[0]} != 2'b11 || cr3_d[`SCFG_A_ADDR2];
         ser_b_clk_en <= {cr1_d[3], cr1_d[1]} != 2'b11 || cr3_d[`SCFG_B_ADDR2];
         lpt_en <= cr1_d[5:4] != 2'b11;
         lpt_mode <= scfg_lpt_t'({lpt_mode_bit2, cr0_d[3:2]});
         drive_swap <= cr1_d[`SCFG_SWAP];
         ser_a_div <= cr3_d[`SCFG_A_MIDI] ? `SCFG_DIV_MIDI : `SCFG_DIV_STD;
         ser_b_div <= cr3_d[`SCFG_B_MIDI] ? `SCFG_DIV_MIDI : `SCFG_DIV_STD;
         osc_run <= osc_d;
         int_clk_run <= iclk_d;
         settling <= settle_d != '0;
         adapter_read_strobe_n <= !rstb_d;
         adapter_write_strobe_n <= !wstb_d;
         adapter_data_lines <= xd_d;
         adapter_data_oe <= xoe_d;
         adapter_addr_low <= io_addr[2:0];
      end
   end
endmodule : scfg_top

/* File: verification/scfg_chk.sv */
// Purpose: port-level checks of the configuration block
// Assumes: one clock domain, cold reset on rst
// Notes: bound to scfg_top below
module scfg_chk (
   input wire logic mclk,
   input wire logic rst,
   input wire logic [9:0] io_addr,
   input wire logic io_rd,
   input wire logic io_wr,
   input wire logic fdc_busy,
   input wire logic power_select_bit2,
   input wire logic [7:0] io_rdata,
   input wire logic io_rdata_oe,
   input wire logic hdd_hit,
   input wire logic fdc_hit,
   input wire logic osc_run,
   input wire logic int_clk_run,
   input wire logic settling,
   input wire logic adapter_read_strobe_n,
   input wire logic adapter_write_strobe_n,
   input wire logic adapter_data_oe
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   // with power_select_bit2 low, only code 11 stops the clock with the oscillator on and no settle
   sequence s_asleep;
      osc_run && !int_clk_run && !settling && !power_select_bit2;
   endsequence
   sequence s_wake;
      s_asleep ##1 $rose(fdc_busy);
   endsequence
   a_rdata_cause: assert property (io_rdata_oe |-> $past(io_rd) &&
      $past(io_addr) == 10'h252)
      else $error("read data enable without data port read");
   a_rdata_idle: assert property (!io_rdata_oe |-> io_rdata == 8'h00)
      else $error("read data not zero outside a read");
   a_hdd_range: assert property (hdd_hit |-> ($past(io_rd) || $past(io_wr)) &&
      (($past(io_addr) >> 3) inside {10'h3e, 10'h2e} ||
      ($past(io_addr) >> 1) inside {10'h1fb, 10'h1bb}))
      else $error("disk hit outside its ranges");
   a_fdc_range: assert property (fdc_hit |-> ($past(io_addr) >> 3) inside {10'h7e, 10'h6e})
      else $error("floppy hit outside its ranges");
   a_osc_stop: assert property (!osc_run |-> !int_clk_run)
      else $error("internal clock runs with oscillator stopped");
   a_settle_hold: assert property (settling |-> !int_clk_run)
      else $error("internal clock runs while settling");
   a_wake_fast: assert property (s_wake |-> ##[0:2] int_clk_run)
      else $error("no prompt wake from automatic sleep");
   a_wr_strobe_data: assert property (!adapter_write_strobe_n |-> adapter_data_oe)
      else $error("adapter write strobe without data drive");
   a_rd_strobe_cause: assert property (!adapter_read_strobe_n && adapter_write_strobe_n
      |-> $past(io_rd))
      else $error("adapter read strobe without host read");
endmodule : scfg_chk
bind scfg_top scfg_chk i_chk (.mclk, .rst, .io_addr, .io_rd, .io_wr, .fdc_busy,
   .power_select_bit2, .io_rdata, .io_rdata_oe, .hdd_hit, .fdc_hit, .osc_run, .int_clk_run,
   .settling, .adapter_read_strobe_n, .adapter_write_strobe_n, .adapter_data_oe);

/* File: verification/scfg_host.sv */
// Purpose: isa host issuing i/o cycles to the block
// Assumes: one cycle per access, driven 1 ns after the rising edge
// Notes: released data lines show the inverse of the last value
module scfg_host (
   input wire logic mclk,
   output logic [9:0] io_addr,
   output logic io_rd,
   output logic io_wr,
   output logic [7:0] io_wdata
);
   timeunit 1ns;
   timeprecision 100ps;
   initial
   begin
      io_addr = 10'h000;
      io_rd = 1'b0;
      io_wr = 1'b0;
      io_wdata = 8'h00;
   end
   task automatic cycle(input logic [9:0] a, input logic rd, input logic [7:0] d);
      @(posedge mclk);
      #1;
      io_addr = a;
      io_rd = rd;
      io_wr = !rd;
      io_wdata = d;
      @(posedge mclk);
      #1;
      io_rd = 1'b0;
      io_wr = 1'b0;
      io_wdata = ~d;
   endtask : cycle
   task automatic cfg(input logic [3:0] idx, input logic rd, input logic [7:0] d);
      cycle(10'h250, 1'b0, 8'h89);
      cycle(10'h251, 1'b0, {4'h0, idx});
      cycle(10'h252, rd, d);
   endtask : cfg
endmodule : scfg_host

/* File: verification/tb.sv */
// Purpose: self-checking bench for the configuration block
// Assumes: ce held high; short settle and idle counts
// Notes: host cycles come from scfg_host
module tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic mclk, rst, ce, io_rd, io_wr, io_rdata_oe;
   logic [9:0] io_addr;
   logic [7:0] io_wdata, io_rdata, adapter_data_lines;
   logic [10:0] straps;
   logic lpt_mode_bit2, power_select_bit2, fdc_busy, fdc_motor_on, uart_irq_src;
   logic serial_a_out, serial_b_out, serial_a_in, serial_b_in, adapter_dma_ack;
   logic [1:0] idle_timer_sel;
   logic hdd_hit, fdc_hit, ser_a_hit, ser_b_hit, lpt_hit, fdc_clk_en, ser_a_clk_en;
   logic ser_b_clk_en, lpt_en, drive_swap, osc_run, int_clk_run, settling;
   logic adapter_read_strobe_n, adapter_write_strobe_n, adapter_data_oe;
   logic [3:0] ser_a_div, ser_b_div;
   logic [2:0] adapter_addr_low;
   scfg_pkg::scfg_lpt_t lpt_mode;
   int errors, total_checks, n;
   scfg_top #(.SETTLE_CYC(24'd20), .IDLE_CYC0(24'd8), .IDLE_CYC1(24'd16),
      .IDLE_CYC2(24'd32), .IDLE_CYC3(24'd64)) i_dut (
      .mclk, .rst, .ce, .io_addr, .io_rd, .io_wr, .io_wdata, .io_rdata, .io_rdata_oe,
      .strap_hdd_dis(straps[10]), .strap_hdd_sel(straps[9]), .strap_fdc_dis(straps[8]),
      .strap_fdc_sel(straps[7]), .strap_swap(straps[6]), .strap_ser_a(straps[5:4]),
      .strap_ser_b(straps[3:2]), .strap_lpt(straps[1:0]), .lpt_mode_bit2,
      .power_select_bit2, .idle_timer_sel, .fdc_busy, .fdc_motor_on, .uart_irq_src,
      .serial_a_out, .serial_b_out, .serial_a_in, .serial_b_in, .adapter_dma_ack,
      .hdd_hit, .fdc_hit, .ser_a_hit, .ser_b_hit, .lpt_hit, .fdc_clk_en, .ser_a_clk_en,
      .ser_b_clk_en, .lpt_en, .lpt_mode(lpt_mode), .drive_swap, .ser_a_div, .ser_b_div,
      .osc_run, .int_clk_run, .settling, .adapter_read_strobe_n, .adapter_write_strobe_n,
      .adapter_data_lines, .adapter_data_oe, .adapter_addr_low);
   scfg_host i_host (.mclk, .io_addr, .io_rd, .io_wr, .io_wdata);
   task automatic tick(input int k);
      repeat (k) @(posedge mclk);
      #1;
   endtask : tick
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         errors++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic close_out();
      $display("checks %0d mismatches %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : close_out
   task automatic probe(input logic [9:0] a, input logic [4:0] e);
      i_host.cycle(a, 1'b1, 8'h00);
      chk({3'h0, hdd_hit, fdc_hit, ser_a_hit, ser_b_hit, lpt_hit}, {3'h0, e});
   endtask : probe
   task automatic xs(input logic [9:0] a, input logic rd, input logic ack, input logic [1:0] e);
      adapter_dma_ack = ack;
      i_host.cycle(a, rd, 8'h5a);
      adapter_dma_ack = 1'b0;
      chk({6'h0, adapter_read_strobe_n, adapter_write_strobe_n}, {6'h0, e});
   endtask : xs
   task automatic t_straps(input logic [10:0] s, input logic [7:0] c0, input logic [7:0] c1);
      straps = s;
      rst = 1'b1;
      tick(5);
      rst = 1'b0;
      tick(2);
      i_host.cfg(4'h0, 1'b1, 8'h00);
      chk(io_rdata, c0);
      i_host.cfg(4'h1, 1'b1, 8'h00);
      chk(io_rdata, c1);
      chk({7'h0, drive_swap}, {7'h0, s[6]});
   endtask : t_straps
   task automatic t_lock();
      i_host.cycle(10'h250, 1'b0, 8'h88);
      i_host.cycle(10'h251, 1'b0, 8'h07);
      i_host.cycle(10'h252, 1'b1, 8'h00);
      chk({io_rdata_oe, io_rdata[6:0]}, 8'h80);
      i_host.cycle(10'h250, 1'b0, 8'h00);
      i_host.cycle(10'h252, 1'b1, 8'h00);
      chk({7'h0, io_rdata_oe}, 8'h00);
   endtask : t_lock
   task automatic t_decode();
      logic [9:0] sa [3] = '{10'h2e8, 10'h3e8, 10'h3f8};
      logic [9:0] sb [3] = '{10'h3e8, 10'h2e8, 10'h2f8};
      logic [9:0] sl [3] = '{10'h3bc, 10'h278, 10'h378};
      i_host.cfg(4'h0, 1'b0, 8'h50);
      probe(10'h1f7, 5'h10);
      probe(10'h3f0, 5'h08);
      probe(10'h170, 5'h00);
      for (int i = 0; i < 3; i++)
      begin
         i_host.cfg(4'h1, 1'b0, {2'h0, i[1], i[0], i[1], i[1], i[0], i[0]});
         probe(sa[i], 5'h04);
         probe(sb[i] + 10'h7, 5'h02);
         probe(sl[i] + 10'h3, 5'h01);
         probe(sl[i] + 10'h4, 5'h00);
      end
      i_host.cfg(4'h1, 1'b0, 8'h3f);
      chk({5'h0, ser_a_clk_en, ser_b_clk_en, lpt_en}, 8'h00);
      probe(10'h3f8, 5'h00);
      i_host.cfg(4'h0, 1'b0, 8'h00);
      probe(10'h177, 5'h10);
      probe(10'h370, 5'h08);
      i_host.cfg(4'h0, 1'b0, 8'ha0);
      chk({7'h0, fdc_clk_en}, 8'h00);
      probe(10'h170, 5'h00);
      probe(10'h377, 5'h00);
   endtask : t_decode
   task automatic t_modes();
      for (int m = 0; m < 8; m++)
      begin
         lpt_mode_bit2 = m[2];
         i_host.cfg(4'h0, 1'b0, {4'h5, m[1:0], 2'h0});
         chk({5'h0, lpt_mode}, 8'(m));
      end
      lpt_mode_bit2 = 1'b0;
      i_host.cfg(4'h3, 1'b0, 8'h03);
      chk({ser_a_div, ser_b_div}, 8'hcc);
      i_host.cfg(4'h3, 1'b0, 8'h00);
      chk({ser_a_div, ser_b_div}, 8'hdd);
   endtask : t_modes
   task automatic t_power();
      power_select_bit2 = 1'b1;
      tick(2);
      chk({7'h0, int_clk_run}, 8'h00);
      power_select_bit2 = 1'b0;
      tick(2);
      chk({7'h0, int_clk_run}, 8'h01);
      i_host.cfg(4'h0, 1'b0, 8'h51);
      tick(2);
      chk({6'h0, osc_run, int_clk_run}, 8'h00);
      i_host.cfg(4'h0, 1'b0, 8'h50);
      chk({7'h0, settling}, 8'h01);
      for (n = 0; n < 60 && !int_clk_run; n++)
         tick(1);
      chk({7'h0, n >= 18 && n <= 24}, 8'h01);
      idle_timer_sel = 2'h1;
      i_host.cfg(4'h0, 1'b0, 8'h52);
      tick(4);
      {fdc_motor_on, uart_irq_src, serial_a_out, serial_b_out, serial_b_in} = 5'h18;
      tick(1);
      {fdc_motor_on, uart_irq_src, serial_a_out, serial_b_out, serial_b_in} = 5'h07;
      for (n = 0; n < 100 && int_clk_run; n++)
         tick(1);
      chk({7'h0, n >= 16 && n <= 20}, 8'h01);
      tick(1);
      chk({6'h0, osc_run, int_clk_run}, 8'h02);
      fdc_busy = 1'b1;
      tick(2);
      chk({7'h0, int_clk_run}, 8'h01);
      fdc_busy = 1'b0;
      i_host.cfg(4'h0, 1'b1, 8'h00);
      chk(io_rdata, 8'h52);
   endtask : t_power
   task automatic t_adapter();
      i_host.cfg(4'h0, 1'b0, 8'h58);
      i_host.cfg(4'h2, 1'b0, 8'hc0);
      for (n = 0; n < 3 && (adapter_read_strobe_n || adapter_write_strobe_n); n++)
         tick(1);
      chk({adapter_read_strobe_n, adapter_write_strobe_n, 5'h0, adapter_data_oe}, 8'h01);
      chk(adapter_data_lines, 8'hc0);
      xs(10'h300, 1'b1, 1'b0, 2'b01);
      xs(10'h307, 1'b0, 1'b0, 2'b10);
      chk({adapter_data_lines[4:0], adapter_addr_low}, 8'hd7);
      xs(10'h308, 1'b1, 1'b0, 2'b11);
      i_host.cfg(4'h2, 1'b0, 8'hc1);
      xs(10'h30f, 1'b1, 1'b0, 2'b01);
      xs(10'h310, 1'b0, 1'b0, 2'b11);
      xs(10'h123, 1'b1, 1'b1, 2'b01);
   endtask : t_adapter
   initial
   begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   initial
   begin
      #200000;
      errors++;
      close_out();
   end
   initial
   begin
      ce = 1'b1;
      {lpt_mode_bit2, power_select_bit2, fdc_busy, fdc_motor_on, uart_irq_src} = 5'h00;
      {serial_a_out, serial_b_out, serial_a_in, serial_b_in} = 4'hf;
      {adapter_dma_ack, idle_timer_sel} = 3'h0;
      errors = 0;
      total_checks = 0;
      t_straps(11'h2aa, 8'h50, 8'h2c);
      t_lock();
      t_decode();
      t_modes();
      t_power();
      t_adapter();
      t_straps(11'h555, 8'ha0, 8'h93);
      close_out();
   end
endmodule : tb
